// ### design/reset_watchdog_defines.vh
`ifndef RESET_WATCHDOG_DEFINES_VH
`define RESET_WATCHDOG_DEFINES_VH

// Word offsets on the register bus (one register per address)
`define OFF_SETUP        4'h0
`define OFF_SERVICE      4'h1
`define OFF_CONTROL      4'h2
`define OFF_STATUS       4'h3
`define OFF_MASK         4'h4

// Setup register field positions
`define SETUP_RATE_LO    0
`define SETUP_RATE_HI    1
`define SETUP_CM_EN      3
`define SETUP_DLY_EN     4
`define SETUP_EDGE_SEL   5
`define SETUP_RESET      8'h10
`define SETUP_IMPL_MASK  8'h3b

// Control register field positions
`define CTRL_WD_DIS      0
`define CTRL_SPECIAL     1

// Status/mask bits: reset cause events
`define EV_PIN           0
`define EV_POR           1
`define EV_CLKMON        2
`define EV_WDOG          3

// Service byte values
`define SERVICE_ARM      8'h55
`define SERVICE_CLEAR    8'haa

// Timing
`define PROTECT_CYCLES   64
`define WD_BASE_LOG2     15
`define STOP_DELAY_CYC   4064
`define PIN_MIN_CYC      8
`define RST_DRIVE_CYC    5'h10
`define CLK_HZ           250000000
`define CLKMON_LOW_HZ    10000

`endif

// ### design/clock_monitor.v
`timescale 1ns/1ps
// Watches a toggle that the monitored clock domain produces; reports loss
// when no edge of it is seen for a full timeout window.
module clock_monitor #(
  parameter TIMEOUT = 25000
) (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire enable_i,
  input  wire tick_i,
  output reg  fail_o
);
  reg        s1_r;
  reg        s2_r;
  reg        s3_r;
  reg [31:0] cnt_r;

  // Two-stage synchroniser; edge taken from the second and third stages
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= tick_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Silence counter; disabled monitor never fails
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 32'h0;
      fail_o <= 1'b0;
    end else if (!enable_i || (s2_r != s3_r)) begin
      cnt_r  <= 32'h0;
      fail_o <= 1'b0;
    end else if (cnt_r >= TIMEOUT - 1) begin
      fail_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
endmodule // clock_monitor

// ### design/reset_watchdog_clock_monitor.v
// What this block does
// - Four reset causes: reset pin, power-on, clock monitor fail, watchdog timeout.
// - Pin still low after power-on delay keeps device in reset until high.
// - Watchdog expiry resets device and drives reset pin low.
// - Watchdog enabled from reset; disable bit accepts one write per reset, any number in special mode.
// - Service by writing 55 then aa; only that ordered pair restarts timeout.
// - Any number of other bus cycles may sit between arm and clear writes.
// - Two protected rate bits pick one of four timeout periods.
// - Base divide two to fifteen, extra 1, 4, 16, 64; bits clear at reset.
// - Enabled clock monitor resets and drives pin low on clock loss.
// - Normal mode: bits 5,4,1,0 written once, within 64 cycles of reset.
// - Special mode makes protected bits writable anytime; bit 3 always writable.
// - Setup bits 7, 6 and 2 read zero.
// - Edge select: 1 falling-edge interrupt, 0 low-level; write-once early.
// - Stop delay bit set by reset; 1 waits 4064 cycles after wakeup.
// - Clock monitor enable bit switches the monitor on and off.
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "reset_watchdog_defines.vh"
module reset_watchdog_clock_monitor #(
  parameter WD_BASE_LOG2   = `WD_BASE_LOG2,
  parameter STOP_DELAY_CYC = `STOP_DELAY_CYC,
  parameter POR_DELAY_CYC  = 16,
  parameter CLKMON_TIMEOUT = `CLK_HZ / `CLKMON_LOW_HZ
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        reset_pin_in_i,
  output reg         reset_pin_out_o,
  output reg         reset_pin_oe_o,
  input  wire        ext_irq_n_i,
  input  wire        mon_tick_i,
  input  wire        stop_wakeup_i,
  output reg         ext_irq_o,
  output reg         sys_reset_n_o,
  output reg         resume_o,
  output reg         irq_o
);
  localparam WD_W = WD_BASE_LOG2 + 7;

  reg  [7:0]      setup_r;
  reg             setup_written_r;
  reg             wd_dis_r;
  reg             wd_dis_written_r;
  reg             special_r;
  reg  [6:0]      age_r;
  reg             armed_r;
  reg  [WD_W-1:0] wd_cnt_r;
  reg  [3:0]      status_r;
  reg  [3:0]      mask_r;
  reg  [15:0]     por_cnt_r;
  reg  [4:0]      drive_cnt_r;
  reg  [3:0]      pin_low_cnt_r;
  reg             pin_s1_r;
  reg             pin_s2_r;
  reg             irq_s1_r;
  reg             irq_s2_r;
  reg             irq_s3_r;
  reg  [12:0]     stop_cnt_r;
  reg             stopping_r;
  reg             acc_done_r;
  reg  [3:0]      ev_nxt;
  reg  [WD_W-1:0] wd_limit;
  wire            clkmon_fail;
  wire            acc;
  wire            wr;
  wire            rd;
  wire            early;
  wire            prot_ok;
  wire            wd_expire;
  wire            internal_rst;
  wire            pin_ev;

  // Single wait state: waitrequest drops one cycle after the request rises
  assign acc = (avs_read_i | avs_write_i) & ~acc_done_r;
  assign wr  = avs_write_i & ~avs_waitrequest_o; // Lands at the edge the master sees
  assign rd  = avs_read_i & acc;
  assign early   = (age_r < `PROTECT_CYCLES);
  assign prot_ok = special_r | (early & ~setup_written_r);

  // Timeout length: base period times 1, 4, 16 or 64
  always @* begin
    case (setup_r[`SETUP_RATE_HI:`SETUP_RATE_LO])
      2'b00:   wd_limit = {{(WD_W-1){1'b0}}, 1'b1} << WD_BASE_LOG2;
      2'b01:   wd_limit = {{(WD_W-1){1'b0}}, 1'b1} << (WD_BASE_LOG2 + 2);
      2'b10:   wd_limit = {{(WD_W-1){1'b0}}, 1'b1} << (WD_BASE_LOG2 + 4);
      default: wd_limit = {{(WD_W-1){1'b0}}, 1'b1} << (WD_BASE_LOG2 + 6);
    endcase
  end

  assign wd_expire    = ~wd_dis_r & (wd_cnt_r >= wd_limit - 1'b1);
  assign internal_rst = wd_expire | clkmon_fail;
  assign pin_ev       = (pin_low_cnt_r == `PIN_MIN_CYC - 1) & ~pin_s2_r;

  clock_monitor #(
    .TIMEOUT (CLKMON_TIMEOUT)
  ) u_clock_monitor (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .enable_i (setup_r[`SETUP_CM_EN]),
    .tick_i   (mon_tick_i),
    .fail_o   (clkmon_fail)
  );

  // Pin and interrupt synchronisers
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      irq_s1_r <= 1'b1;
      irq_s2_r <= 1'b1;
      irq_s3_r <= 1'b1;
    end else begin
      pin_s1_r <= reset_pin_in_i;
      pin_s2_r <= pin_s1_r;
      irq_s1_r <= ext_irq_n_i;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
    end
  end

  // Reset sequencing: power-on delay, pin hold, pin drive on internal faults
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_cnt_r       <= 16'h0;
      drive_cnt_r     <= 5'h0;
      pin_low_cnt_r   <= 4'h0;
      sys_reset_n_o   <= 1'b0;
      reset_pin_out_o <= 1'b0;
      reset_pin_oe_o  <= 1'b0;
    end else begin
      if (por_cnt_r < POR_DELAY_CYC)
        por_cnt_r <= por_cnt_r + 16'h1;
      if (internal_rst)
        drive_cnt_r <= `RST_DRIVE_CYC;
      else if (drive_cnt_r != 5'h0)
        drive_cnt_r <= drive_cnt_r - 5'h1;
      if (pin_s2_r)
        pin_low_cnt_r <= 4'h0;
      else if (pin_low_cnt_r != `PIN_MIN_CYC - 1)
        pin_low_cnt_r <= pin_low_cnt_r + 4'h1;
      reset_pin_oe_o <= internal_rst | (drive_cnt_r > 5'h1);
      // Held in reset while pin low, even past the power-on delay
      sys_reset_n_o  <= (por_cnt_r >= POR_DELAY_CYC) & pin_s2_r &
                        ~internal_rst & (drive_cnt_r == 5'h0);
    end
  end

  // Register file, watchdog and service sequence; all but special flag and mask cleared by any reset cause
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setup_r          <= `SETUP_RESET;
      setup_written_r  <= 1'b0;
      wd_dis_r         <= 1'b0;
      wd_dis_written_r <= 1'b0;
      special_r        <= 1'b0;
      age_r            <= 7'h0;
      armed_r          <= 1'b0;
      wd_cnt_r         <= {WD_W{1'b0}};
      mask_r           <= 4'h0;
    end else if (!sys_reset_n_o) begin
      // Internal reset restores control state; special flag and mask survive
      setup_r          <= `SETUP_RESET;
      setup_written_r  <= 1'b0;
      wd_dis_r         <= 1'b0;
      wd_dis_written_r <= 1'b0;
      age_r            <= 7'h0;
      armed_r          <= 1'b0;
      wd_cnt_r         <= {WD_W{1'b0}};
    end else begin
      if (early)
        age_r <= age_r + 7'h1;
      if (wd_dis_r)
        wd_cnt_r <= {WD_W{1'b0}};
      else
        wd_cnt_r <= wd_cnt_r + 1'b1;
      if (wr && avs_address_i == `OFF_SETUP) begin
        // Bit 3 free; protected bits only inside the window or in special mode
        setup_r[`SETUP_CM_EN] <= avs_writedata_i[`SETUP_CM_EN];
        if (prot_ok) begin
          setup_r[`SETUP_EDGE_SEL] <= avs_writedata_i[`SETUP_EDGE_SEL];
          setup_r[`SETUP_DLY_EN]   <= avs_writedata_i[`SETUP_DLY_EN];
          setup_r[`SETUP_RATE_HI]  <= avs_writedata_i[`SETUP_RATE_HI];
          setup_r[`SETUP_RATE_LO]  <= avs_writedata_i[`SETUP_RATE_LO];
          setup_written_r          <= 1'b1;
        end
      end else if (wr && avs_address_i == `OFF_SERVICE) begin
        if (avs_writedata_i[7:0] == `SERVICE_ARM)
          armed_r <= 1'b1;
        else if (avs_writedata_i[7:0] == `SERVICE_CLEAR && armed_r) begin
          wd_cnt_r <= {WD_W{1'b0}};
          armed_r  <= 1'b0;
        end
      end else if (wr && avs_address_i == `OFF_CONTROL) begin
        if (!wd_dis_written_r || special_r) begin
          wd_dis_r         <= avs_writedata_i[`CTRL_WD_DIS];
          wd_dis_written_r <= 1'b1;
        end
        special_r <= avs_writedata_i[`CTRL_SPECIAL];
      end else if (wr && avs_address_i == `OFF_MASK) begin
        mask_r <= avs_writedata_i[3:0];
      end
    end
  end

  // Reset-cause events; set wins over the clear-on-read
  always @* begin
    ev_nxt = 4'h0;
    ev_nxt[`EV_PIN]    = pin_ev;
    ev_nxt[`EV_POR]    = (por_cnt_r == POR_DELAY_CYC - 1);
    ev_nxt[`EV_CLKMON] = clkmon_fail;
    ev_nxt[`EV_WDOG]   = wd_expire;
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_r <= 4'h0;
      irq_o    <= 1'b0;
    end else begin
      if (rd && avs_address_i == `OFF_STATUS)
        status_r <= ev_nxt;
      else
        status_r <= status_r | ev_nxt;
      irq_o <= |((status_r | ev_nxt) & mask_r &
                 ~((rd && avs_address_i == `OFF_STATUS) ? status_r : 4'h0));
    end
  end

  // External interrupt sensing: falling edge pulse or low level
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      ext_irq_o <= 1'b0;
    else if (setup_r[`SETUP_EDGE_SEL])
      ext_irq_o <= irq_s3_r & ~irq_s2_r;
    else
      ext_irq_o <= ~irq_s2_r;
  end

  // Stop wakeup: optional stabilisation delay before resuming
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_cnt_r <= 13'h0;
      stopping_r <= 1'b0;
      resume_o   <= 1'b0;
    end else begin
      resume_o <= 1'b0;
      if (stop_wakeup_i && !stopping_r) begin
        if (setup_r[`SETUP_DLY_EN]) begin
          stopping_r <= 1'b1;
          stop_cnt_r <= 13'h0;
        end else begin
          resume_o <= 1'b1;
        end
      end else if (stopping_r) begin
        if (stop_cnt_r == STOP_DELAY_CYC - 1) begin
          stopping_r <= 1'b0;
          resume_o   <= 1'b1;
        end else begin
          stop_cnt_r <= stop_cnt_r + 13'h1;
        end
      end
    end
  end

  // Bus answer: waitrequest high until one cycle into the request
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_done_r        <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      acc_done_r        <= acc;
      avs_waitrequest_o <= ~acc;
      if (rd) begin
        if (avs_address_i == `OFF_SETUP)
          avs_readdata_o <= {24'h0, setup_r & `SETUP_IMPL_MASK};
        else if (avs_address_i == `OFF_CONTROL)
          avs_readdata_o <= {30'h0, special_r, wd_dis_r};
        else if (avs_address_i == `OFF_STATUS)
          avs_readdata_o <= {28'h0, status_r};
        else if (avs_address_i == `OFF_MASK)
          avs_readdata_o <= {28'h0, mask_r};
        else
          avs_readdata_o <= 32'h0;
      end
    end
  end
endmodule // reset_watchdog_clock_monitor

// ### testbench/reset_watchdog_clock_monitor_props.sv
`timescale 1ns/1ps
// Port-level checks of bus timing, reset line drive and pulses
module reset_watchdog_clock_monitor_props (
  input wire        clk_i,
  input wire        rst_n_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        reset_pin_in_i,
  input wire        reset_pin_out_o,
  input wire        reset_pin_oe_o,
  input wire        sys_reset_n_o,
  input wire        resume_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire req;
  // Either bus direction counts as a request
  assign req = avs_read_i | avs_write_i;
  wait_answer_a:
    assert property ($rose(req) |=> !avs_waitrequest_o) else $error("bus answer late");
  wait_once_a:
    assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer too long");
  rdata_hold_a:
    assert property ($changed(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o)
      else $error("read data moved");
  drive_low_a:
    assert property (reset_pin_oe_o |-> !reset_pin_out_o) else $error("line driven high");
  drive_hold_a:
    assert property ($rose(reset_pin_oe_o) |-> reset_pin_oe_o [*8]) else $error("drive short");
  drive_reset_a:
    assert property (reset_pin_oe_o [*2] |-> !sys_reset_n_o) else $error("no reset on fault");
  pin_hold_a:
    assert property (!reset_pin_in_i [*8] ##1 !reset_pin_in_i [*3] |-> !sys_reset_n_o)
      else $error("pin low ignored");
  resume_pulse_a:
    assert property (resume_o |=> !resume_o) else $error("resume not a pulse");
endmodule // reset_watchdog_clock_monitor_props

bind reset_watchdog_clock_monitor reset_watchdog_clock_monitor_props u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .reset_pin_in_i(reset_pin_in_i), .reset_pin_out_o(reset_pin_out_o),
  .reset_pin_oe_o(reset_pin_oe_o), .sys_reset_n_o(sys_reset_n_o), .resume_o(resume_o));

// ### testbench/reset_pin_partner.sv
`timescale 1ns/1ps
// External reset circuit on the shared, pulled-up reset line
module reset_pin_partner (
  input  wire       clk_i,
  input  wire       req_i,
  input  wire [7:0] len_i,
  input  wire       oe_i,
  input  wire       out_i,
  output wire       pin_o,
  output reg  [7:0] drive_cnt_o
);
  reg [7:0] low_r = 8'h00;
  initial drive_cnt_o = 8'h00;
  // Pull-up wins only while nobody pulls the line down
  assign pin_o = !(low_r != 8'h00 || (oe_i && !out_i));
  // Short requests are stretched so the device can tell them apart
  always @(posedge clk_i) begin
    if (req_i)
      low_r <= (len_i < 8'h08) ? 8'h08 : len_i;
    else if (low_r != 8'h00)
      low_r <= low_r - 8'h01;
    if (oe_i)
      drive_cnt_o <= drive_cnt_o + 8'h01;
  end
endmodule // reset_pin_partner

// ### testbench/reset_watchdog_clock_monitor_bench.sv
`timescale 1ns/1ps
`include "reset_watchdog_defines.vh"
module reset_watchdog_clock_monitor_bench;
  reg         clk_i, rst_n_i, rd, wr, tick, tick_en, wake, preq, xirq;
  reg  [3:0]  adr;
  reg  [31:0] wdat;
  reg  [7:0]  plen, q, v, setup_m, c0;
  wire [31:0] rdat;
  wire        waitr, pin, pout, poe, sysr, resume, irq, xo;
  wire [7:0]  dcnt;
  integer     bad_count, checked, n, r, d;
  // Short counts keep every timeout within a few thousand cycles
  reset_watchdog_clock_monitor #(.WD_BASE_LOG2(4), .STOP_DELAY_CYC(20),
    .POR_DELAY_CYC(16), .CLKMON_TIMEOUT(50)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(waitr), .reset_pin_in_i(pin), .reset_pin_out_o(pout),
    .reset_pin_oe_o(poe), .ext_irq_n_i(xirq), .mon_tick_i(tick),
    .stop_wakeup_i(wake), .ext_irq_o(xo), .sys_reset_n_o(sysr), .resume_o(resume),
    .irq_o(irq));
  reset_pin_partner partner (.clk_i(clk_i), .req_i(preq), .len_i(plen), .oe_i(poe),
    .out_i(pout), .pin_o(pin), .drive_cnt_o(dcnt));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Monitored clock toggles at random, well inside the loss window
  always @(posedge clk_i) begin
    if (tick_en && $urandom_range(3) == 0)
      tick <= ~tick;
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task hang;
    begin
      bad_count = bad_count + 1;
      final_report;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e, input string nm);
    begin
      checked = checked + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("wrong value %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low, then an idle edge
  task bus(input w, input [3:0] a, input [7:0] dat);
    integer k;
    begin
      adr <= a;
      wdat <= {24'h0, dat};
      wr <= w;
      rd <= !w;
      k = 0;
      do begin
        @(posedge clk_i);
        k = k + 1;
      end while (waitr !== 1'b0 && k < 50);
      if (k >= 50)
        hang;
      q = rdat[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // Counts edges until line drive (0), system up (1) or resume (2)
  task waitfor(input integer m, output integer k);
    begin
      k = 0;
      while (!(m == 0 ? poe === 1'b1 : m == 1 ? sysr === 1'b1 : resume === 1'b1)
             && k < 3000) begin
        @(posedge clk_i);
        k = k + 1;
      end
      if (k >= 3000)
        hang;
    end
  endtask
  initial begin
    {rst_n_i, rd, wr, tick, wake, preq, plen, adr, wdat} = 0;
    tick_en = 1'b1;
    xirq = 1'b1;
    bad_count = 0;
    checked = 0;
    v = $urandom(26877);
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    waitfor(1, n);
    chk(n >= 17 && n <= 18, 1, "por delay");
    bus(0, `OFF_SETUP, 8'h00);
    chk(q, `SETUP_RESET, "setup reset");
    bus(0, `OFF_STATUS, 8'h00);
    chk(q & 8'h02, 8'h02, "por event");
    bus(0, 4'h5, 8'h00);
    chk(q, 8'h00, "unmapped");
    // Early normal-mode writes: first one sticks, later only bit 3 moves
    v = $urandom | 8'h03;
    bus(1, `OFF_SETUP, v);
    bus(1, `OFF_SETUP, ~v);
    setup_m = (v & 8'h33) | (~v & 8'h08);
    bus(0, `OFF_SETUP, 8'h00);
    chk(q, setup_m, "setup once");
    bus(1, `OFF_CONTROL, 8'h01);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    waitfor(2, n);
    d = setup_m[4] ? 20 : 0;
    chk(n + 2 >= d && n <= d + 3, 1, "stop delay");
    repeat (64) @(posedge clk_i);
    bus(1, `OFF_SETUP, 8'h00);
    bus(0, `OFF_SETUP, 8'h00);
    chk(q, setup_m & 8'hf7, "setup late");
    bus(1, `OFF_CONTROL, 8'h03);
    bus(1, `OFF_SETUP, 8'hff);
    bus(0, `OFF_SETUP, 8'h00);
    chk(q, 8'h3b, "special write");
    // Edge mode gives a single pulse; level mode follows the pin while low
    xirq <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(xo, 1'b1, "irq edge");
    @(posedge clk_i);
    chk(xo, 1'b0, "irq pulse");
    bus(1, `OFF_SETUP, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(xo, 1'b1, "irq level");
    xirq <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(xo, 1'b0, "irq idle");
    $display("test setup done");
    // Each rate, serviced with traffic between arm and clear, then left to expire
    for (r = 0; r < 4; r = r + 1) begin
      bus(1, `OFF_MASK, r ? 8'h08 : 8'h00);
      bus(1, `OFF_SETUP, r[7:0]);
      bus(1, `OFF_CONTROL, 8'h02);
      bus(1, `OFF_SERVICE, `SERVICE_ARM);
      bus(0, `OFF_SETUP, 8'h00);
      bus(1, `OFF_SERVICE, `SERVICE_CLEAR);
      c0 = dcnt;
      if (r == 1) begin
        repeat (30) @(posedge clk_i);
        bus(1, `OFF_SERVICE, `SERVICE_CLEAR);
      end
      waitfor(0, n);
      n = (r == 1) ? n + 33 : n;
      chk(n + 4 >= (16 << 2 * r) && n <= (16 << 2 * r) + 20, 1, "timeout");
      waitfor(1, n);
      bus(1, `OFF_CONTROL, 8'h03);
      // Expiry stays visible one more edge while the reset takes hold
      chk(dcnt - c0, `RST_DRIVE_CYC + 1, "pin drive");
      chk(irq, r != 0, "irq raised");
      bus(0, `OFF_STATUS, 8'h00);
      chk(q & 8'h08, 8'h08, "wdog event");
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0, "irq cleared");
    end
    $display("test watchdog done");
    bus(1, `OFF_SETUP, 8'h08);
    c0 = dcnt;
    repeat (200) @(posedge clk_i);
    chk(dcnt, c0, "monitor quiet");
    tick_en <= 1'b0;
    waitfor(0, n);
    chk(n <= 70, 1, "clock lost");
    waitfor(1, n);
    bus(1, `OFF_CONTROL, 8'h01);
    tick_en <= 1'b1;
    bus(0, `OFF_STATUS, 8'h00);
    chk(q & 8'h04, 8'h04, "monitor event");
    $display("test monitor done");
    bus(1, `OFF_CONTROL, 8'h00);
    bus(0, `OFF_CONTROL, 8'h00);
    chk(q, 8'h01, "disable once");
    c0 = dcnt;
    repeat (1200) @(posedge clk_i);
    chk(dcnt, c0, "wdog off");
    $display("test disable done");
    preq <= 1'b1;
    plen <= 8'h08;
    @(posedge clk_i);
    preq <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(sysr, 1'b0, "pin reset");
    waitfor(1, n);
    bus(1, `OFF_CONTROL, 8'h01);
    bus(0, `OFF_STATUS, 8'h00);
    chk(q & 8'h01, 8'h01, "pin event");
    // Second power-on with the line still held low past the delay
    rst_n_i <= 1'b0;
    preq <= 1'b1;
    plen <= 8'h3c;
    @(posedge clk_i);
    preq <= 1'b0;
    repeat (7) @(posedge clk_i);
    rst_n_i <= 1'b1;
    waitfor(1, n);
    chk(n >= 52 && n <= 75, 1, "pin holds reset");
    $display("test pin done");
    final_report;
  end
endmodule // reset_watchdog_clock_monitor_bench
